// file: level_estimator.sv
// Top and base reference level estimator over one record of samples.
// Notes on behaviour
// RL1 - Mode input selects extreme or histogram method.
// RL2 - Extreme mode: top is max, base min.
// RL3 - Histogram counts samples into 256 level bins.
// RL4 - Sections split at midpoint of min and max.
// RL5 - Fullest bin per section gives top, base.
// RL6 - Midpoint peak in either section: both midpoint.
// RL7 - Ties pick bin farthest from midpoint.
// RL8 - Top is 100 percent, base 0 percent.
// RL9 - Samples are unsigned 8-bit codes 0 to 255.
// RL10 - Valid, last per sample; done pulse after.
`timescale 1ns/100ps
module level_estimator #(
  parameter int CNT_W = level_est_pkg::CNT_W_DEFAULT
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HIST_MODE,
  input wire level_est_pkg::sample_t SAMPLE,
  output logic SAMPLE_READY,
  output level_est_pkg::levels_t LEVELS,
  output logic LEVELS_DONE
);

  level_est_pkg::est_state_t state_q;
  level_est_pkg::est_state_t state_d;
  logic [7:0] min_q;
  logic [7:0] max_q;
  logic [7:0] scan_q;
  logic first_q;
  logic [CNT_W-1:0] lo_cnt_q;
  logic [CNT_W-1:0] hi_cnt_q;
  logic [7:0] lo_lvl_q;
  logic [7:0] hi_lvl_q;
  level_est_pkg::levels_t levels_q;
  logic done_q;
  logic [CNT_W-1:0] bin_count;

  // The first sample of a record always loads, later ones only when more extreme.
  function automatic logic [7:0] extreme_next(
    input logic [7:0] sample,
    input logic [7:0] held,
    input logic first,
    input logic want_max
  );
    logic beyond;
    beyond = want_max ? (sample > held) : (sample < held);
    if (first || beyond) begin
      extreme_next = sample;
    end else begin
      extreme_next = held;
    end
  endfunction

  // Peak test for one section: empty bins never win, and ties move only when the scan runs away from mid.
  function automatic logic peak_wins(
    input logic [CNT_W-1:0] count,
    input logic [CNT_W-1:0] best,
    input logic tie_moves
  );
    peak_wins = 1'b0;
    if (count != '0) begin
      peak_wins = tie_moves ? (count >= best) : (count > best);
    end
  endfunction

  wire collecting = (state_q == level_est_pkg::S_COLLECT);
  wire scanning = (state_q == level_est_pkg::S_SCAN);
  wire finishing = (state_q == level_est_pkg::S_DONE);
  wire accept = collecting && SAMPLE.valid; // RL10
  wire record_end = accept && SAMPLE.last; // RL10
  // Mode is looked at only with the last sample, so it may change freely mid-record.
  wire hist_end = record_end && HIST_MODE; // RL1
  wire minmax_end = record_end && !HIST_MODE; // RL1
  // Samples are taken as unsigned codes, so most positive means largest code.
  wire [7:0] min_d = extreme_next(SAMPLE.data, min_q, first_q, 1'b0); // RL9
  wire [7:0] max_d = extreme_next(SAMPLE.data, max_q, first_q, 1'b1); // RL9
  wire [8:0] span_sum = {1'b0, min_q} + {1'b0, max_q};
  // The floor of the average keeps mid a real code when the span is odd.
  wire [7:0] mid = span_sum[8:1]; // RL4
  wire scan_end = scanning && (scan_q == level_est_pkg::SCAN_LAST);
  wire [7:0] scan_next = scan_q + 8'h01;
  wire done_d = minmax_end || scan_end; // RL10

  // The midpoint bin belongs to both sections so that it can win either.
  wire in_lower = (scan_q <= mid); // RL4
  wire in_upper = (scan_q >= mid); // RL4
  // Lower scan runs toward the midpoint, so a strict compare keeps the farthest tie.
  wire lo_take = scanning && in_lower && peak_wins(bin_count, lo_cnt_q, 1'b0); // RL5 RL7
  // Upper scan runs away from the midpoint, so equal counts move to the farther bin.
  wire hi_take = scanning && in_upper && peak_wins(bin_count, hi_cnt_q, 1'b1); // RL5 RL7
  wire [7:0] lo_lvl_d = lo_take ? scan_q : lo_lvl_q;
  wire [7:0] hi_lvl_d = hi_take ? scan_q : hi_lvl_q;
  wire mid_peak = (lo_lvl_d == mid) || (hi_lvl_d == mid); // RL6
  wire [7:0] hist_top = mid_peak ? mid : hi_lvl_d; // RL6
  wire [7:0] hist_base = mid_peak ? mid : lo_lvl_d; // RL6

  assign SAMPLE_READY = collecting;
  assign LEVELS = levels_q; // RL8
  assign LEVELS_DONE = done_q;

  // Min-max mode skips the scan and goes straight to the done cycle.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      level_est_pkg::S_COLLECT: begin
        if (hist_end) begin
          state_d = level_est_pkg::S_SCAN; // RL1
        end else if (minmax_end) begin
          state_d = level_est_pkg::S_DONE; // RL1
        end
      end
      level_est_pkg::S_SCAN: begin
        if (scan_end) begin
          state_d = level_est_pkg::S_DONE;
        end
      end
      level_est_pkg::S_DONE: begin
        state_d = level_est_pkg::S_COLLECT;
      end
      default: begin
        state_d = level_est_pkg::S_COLLECT;
      end
    endcase
  end

  // Bins are cleared in the done cycle, so a new record may start right after it.
  hist_bins #(
    .CNT_W(CNT_W)
  ) hist_bins_i (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .clear(finishing),
    .inc_en(accept), // RL3
    .inc_addr(SAMPLE.data),
    .rd_addr(scan_q),
    .rd_count(bin_count)
  );

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= level_est_pkg::S_COLLECT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      min_q <= level_est_pkg::LEVEL_RESET;
      max_q <= level_est_pkg::LEVEL_RESET;
    end else if (accept) begin
      min_q <= min_d; // RL2
      max_q <= max_d; // RL2
    end
  end

  // The flag rearms on the last sample, so every record starts its extremes afresh.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_q <= 1'b1;
    end else if (accept) begin
      first_q <= SAMPLE.last; // RL10
    end
  end

  // The scan visits every level once, so a histogram result always costs a full pass.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scan_q <= level_est_pkg::SCAN_FIRST;
    end else if (scanning) begin
      scan_q <= scan_next; // RL3
    end else begin
      scan_q <= level_est_pkg::SCAN_FIRST;
    end
  end

  // The trackers restart on every scan, so a peak from the last record cannot win.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lo_cnt_q <= '0;
      lo_lvl_q <= level_est_pkg::LEVEL_RESET;
    end else if (!scanning) begin
      lo_cnt_q <= '0;
    end else if (lo_take) begin
      lo_cnt_q <= bin_count; // RL5
      lo_lvl_q <= scan_q; // RL5
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_cnt_q <= '0;
      hi_lvl_q <= level_est_pkg::LEVEL_RESET;
    end else if (!scanning) begin
      hi_cnt_q <= '0;
    end else if (hi_take) begin
      hi_cnt_q <= bin_count; // RL5
      hi_lvl_q <= scan_q; // RL5
    end
  end

  // Levels hold until the next record completes, so downstream math sees a stable pair.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      levels_q <= '0;
    end else if (minmax_end) begin
      levels_q <= '{top: max_d, base: min_d}; // RL2 RL8
    end else if (scan_end) begin
      levels_q <= '{top: hist_top, base: hist_base}; // RL5 RL8
    end
  end

  // Done is registered so it lines up with the first cycle of the new levels.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d; // RL10
    end
  end

endmodule

// file: level_est_pkg.sv
// Shared constants and types for the waveform level estimator.
package level_est_pkg;

  localparam int SAMPLE_W = 8;
  localparam int NUM_BINS = 256;
  localparam int CNT_W_DEFAULT = 16;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] SCAN_FIRST = 8'h00;
  localparam logic [7:0] SCAN_LAST = 8'hFF;

  typedef enum logic [1:0] {
    S_COLLECT = 2'b00,
    S_SCAN = 2'b01,
    S_DONE = 2'b11
  } est_state_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [SAMPLE_W-1:0] data;
  } sample_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] top;
    logic [SAMPLE_W-1:0] base;
  } levels_t;

endpackage

// file: hist_bins.sv
// Histogram bin store: one saturating counter per digitizing level.
`timescale 1ns/100ps
module hist_bins #(
  parameter int CNT_W = level_est_pkg::CNT_W_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic inc_en,
  input wire logic [level_est_pkg::SAMPLE_W-1:0] inc_addr,
  input wire logic [level_est_pkg::SAMPLE_W-1:0] rd_addr,
  output logic [CNT_W-1:0] rd_count
);

  logic [CNT_W-1:0] bin_q [level_est_pkg::NUM_BINS];
  wire [CNT_W-1:0] inc_old = bin_q[inc_addr];
  wire inc_sat = &inc_old;
  wire [CNT_W-1:0] inc_new = inc_sat ? inc_old : inc_old + {{(CNT_W-1){1'b0}}, 1'b1};

  assign rd_count = bin_q[rd_addr];

  // Counters saturate so a very long record cannot wrap a peak down to a small count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < level_est_pkg::NUM_BINS; i++) begin
        bin_q[i] <= '0;
      end
    end else if (clear) begin
      for (int i = 0; i < level_est_pkg::NUM_BINS; i++) begin
        bin_q[i] <= '0;
      end
    end else if (inc_en) begin
      bin_q[inc_addr] <= inc_new; // RL3
    end
  end

endmodule

// file: level_est_props.sv
// Port assertions for the level estimator.
`timescale 1ns/100ps
module level_est_props (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HIST_MODE,
  input wire level_est_pkg::sample_t SAMPLE,
  input wire logic SAMPLE_READY,
  input wire level_est_pkg::levels_t LEVELS,
  input wire logic LEVELS_DONE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire e = SAMPLE.valid && SAMPLE_READY && SAMPLE.last;
  property p_mm; e && !HIST_MODE |=> LEVELS_DONE; endproperty
  a_mm: assert property (p_mm) else $error("late done");
  property p_hs; e && HIST_MODE |-> ##257 LEVELS_DONE; endproperty
  a_hs: assert property (p_hs) else $error("late done");
  property p_hq; e && HIST_MODE |=> !LEVELS_DONE [*8]; endproperty
  a_hq: assert property (p_hq) else $error("early done");
  property p_pl; LEVELS_DONE |=> !LEVELS_DONE; endproperty
  a_pl: assert property (p_pl) else $error("long done");
  property p_rd; e |=> !SAMPLE_READY; endproperty
  a_rd: assert property (p_rd) else $error("ready high");
  property p_bk; LEVELS_DONE |-> !SAMPLE_READY ##1 SAMPLE_READY; endproperty
  a_bk: assert property (p_bk) else $error("ready late");
  property p_hd; !LEVELS_DONE |-> $stable(LEVELS); endproperty
  a_hd: assert property (p_hd) else $error("levels moved");
  property p_or; LEVELS_DONE |-> LEVELS.top >= LEVELS.base; endproperty
  a_or: assert property (p_or) else $error("top below base");
endmodule
bind level_estimator level_est_props level_est_props_i (.SYS_CLK, .RST_N, .HIST_MODE, .SAMPLE,
  .SAMPLE_READY, .LEVELS, .LEVELS_DONE);

// file: sample_src.sv
// Record source model feeding samples.
`timescale 1ns/100ps
module sample_src (
  input wire logic clk,
  input wire logic rdy,
  input wire logic go,
  input wire logic [7:0] len,
  output level_est_pkg::sample_t smp
);
  logic [7:0] mem [256];
  logic took = 1'b0;
  int i = 0;
  initial smp = '0;
  always @(posedge clk) took <= smp.valid && rdy;
  // A refused sample is held, and an idle data bus toggles so no stale value looks valid.
  always @(negedge clk) begin
    i = go ? i + int'(took) : 0;
    smp.valid = go && i < len;
    smp.last = i == len - 1;
    smp.data = smp.valid ? mem[i] : ~smp.data;
  end
endmodule

// file: test_level_estimator.sv
// Self-checking bench for the level estimator.
`timescale 1ns/100ps
module test_level_estimator;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic HIST_MODE = 1'b0;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  level_est_pkg::sample_t SAMPLE;
  level_est_pkg::levels_t LEVELS;
  logic SAMPLE_READY;
  logic LEVELS_DONE;
  int n_errors = 0;
  int tests_run = 0;
  level_estimator level_estimator_i (.SYS_CLK, .RST_N, .HIST_MODE, .SAMPLE, .SAMPLE_READY, .LEVELS,
    .LEVELS_DONE);
  sample_src sample_src_i (.clk(SYS_CLK), .rdy(SAMPLE_READY), .go, .len, .smp(SAMPLE));
  initial forever #20 SYS_CLK = ~SYS_CLK;
  task end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task check(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Nonblocking writes so the source sees the new record one edge later, never racing.
  task run(input logic hm, input logic [63:0] v, input int n);
    int k;
    for (k = 0; k < n; k++) sample_src_i.mem[k] = v[63-8*k -: 8];
    HIST_MODE <= hm;
    len <= 8'(n);
    go <= 1'b1;
    for (k = 0; k < 400 && LEVELS_DONE !== 1'b1; k++) @(negedge SYS_CLK);
    if (k == 400) begin
      n_errors++;
      end_sim();
    end else begin
      go <= 1'b0;
      @(negedge SYS_CLK);
    end
  endtask
  task t_minmax;
    run(1'b0, 64'h5AFA034D00000000, 4);
    check(LEVELS, 16'hFA03);
  endtask
  task t_mode;
    run(1'b1, 64'h141414C8C8C8F005, 8);
    check(LEVELS, 16'hC814);
    run(1'b0, 64'h141414C8C8C8F005, 8);
    check(LEVELS, 16'hF005);
  endtask
  task t_ties;
    run(1'b1, 64'h0A1E1E0ADCB4B4DC, 8);
    check(LEVELS, 16'hDC0A);
  endtask
  task t_mid;
    run(1'b1, 64'h00646464C8000000, 5);
    check(LEVELS, 16'h6464);
  endtask
  task t_one;
    run(1'b1, 64'h4D00000000000000, 1);
    check(LEVELS, 16'h4D4D);
  endtask
  initial begin
    repeat (4) @(negedge SYS_CLK);
    RST_N = 1'b1;
    t_minmax();
    t_mode();
    t_ties();
    t_mid();
    t_one();
    end_sim();
  end
endmodule
